/* File: shared/rtc_pkg.sv */
// Shared constants, register map and carrier types for the calendar, adjust and alarm block.
package rtc_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
	localparam int unsigned ALARM_DELAY_NS  = 15_000;
	localparam int unsigned ALARM_DELAY_CYC = ALARM_DELAY_NS / CLK_PERIOD_NS;
	localparam logic [16:0] NOMINAL_COUNT   = 17'h08000;

	// ------------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [3:0] IDX_WEEKDAY  = 4'h3;
	localparam logic [3:0] IDX_DAY      = 4'h4;
	localparam logic [3:0] IDX_MONTH    = 4'h5;
	localparam logic [3:0] IDX_YEAR     = 4'h6;
	localparam logic [3:0] IDX_ADJUST   = 4'h7;
	localparam logic [3:0] IDX_AL_MIN   = 4'h8;
	localparam logic [3:0] IDX_AL_HOUR  = 4'h9;
	localparam logic [3:0] IDX_AL_MASK  = 4'ha;

	// ------------------------------------------------------------------
	// Implemented bits of each register
	// ------------------------------------------------------------------
	localparam logic [7:0] MASK_WEEKDAY = 8'h07;
	localparam logic [7:0] MASK_DAY     = 8'h3f;
	localparam logic [7:0] MASK_MONTH   = 8'h1f;
	localparam logic [7:0] MASK_YEAR    = 8'hff;
	localparam logic [7:0] MASK_ADJUST  = 8'hff;
	localparam logic [7:0] MASK_AL_MIN  = 8'h7f;
	localparam logic [7:0] MASK_AL_HOUR = 8'h3f;
	localparam logic [7:0] MASK_AL_WDAY = 8'h7f;

	// ------------------------------------------------------------------
	// Adjustment register fields
	// ------------------------------------------------------------------
	localparam int unsigned ADJ_INTERVAL_BIT = 7;
	localparam int unsigned ADJ_DIR_BIT      = 6;

	// ------------------------------------------------------------------
	// Calendar values in packed BCD
	// ------------------------------------------------------------------
	localparam logic [7:0] DAY_FIRST   = 8'h01;
	localparam logic [7:0] MONTH_FIRST = 8'h01;
	localparam logic [7:0] MONTH_LAST  = 8'h12;
	localparam logic [7:0] MONTH_FEB   = 8'h02;
	localparam logic [7:0] MONTH_APR   = 8'h04;
	localparam logic [7:0] MONTH_JUN   = 8'h06;
	localparam logic [7:0] MONTH_SEP   = 8'h09;
	localparam logic [7:0] MONTH_NOV   = 8'h11;
	localparam logic [7:0] YEAR_FIRST  = 8'h00;
	localparam logic [7:0] YEAR_LAST   = 8'h99;
	localparam logic [7:0] DAYS_31     = 8'h31;
	localparam logic [7:0] DAYS_30     = 8'h30;
	localparam logic [7:0] DAYS_29     = 8'h29;
	localparam logic [7:0] DAYS_28     = 8'h28;
	localparam logic [7:0] SEC_00      = 8'h00;
	localparam logic [7:0] SEC_20      = 8'h20;
	localparam logic [7:0] SEC_40      = 8'h40;
	localparam logic [2:0] WEEKDAY_LAST = 3'h6;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
	} time_now_s;

	typedef struct packed {
		logic [7:0] day;
		logic [7:0] month;
		logic [7:0] year;
		logic [2:0] weekday;
	} calendar_s;

	typedef enum logic [1:0] {
		AL_IDLE  = 2'b00,
		AL_DELAY = 2'b01,
		AL_HELD  = 2'b11
	} alarm_state_e;

endpackage

/* File: verilog/rtc_calendar_adjust_weekly_alarm.sv */
// Calendar counters, second-length adjustment and weekly alarm compare behind a Wishbone slave.
//
// Notes on behaviour
// - Day counts 1 to 31/30/29/28 by month; February 29 only in leap years.
// - Day wrapping from last day to 1 advances the month.
// - Month counts 1 to 12; wrapping 12 to 1 advances the year.
// - Day, month and year are held as packed BCD tens and units.
// - Interval bit clear: correction at seconds 00, 20 and 40.
// - Interval bit set: correction only at second 00.
// - Direction 0 lengthens the second by (magnitude minus one) times two counts.
// - Direction 1 shortens it by (inverted magnitude plus one) times two.
// - Magnitude bits five to one all zero means no correction.
// - A correction instant coinciding with an adjust write is skipped.
// - Correction changes one second's 32768 oscillator count, that second only.
// - The delivered 32.768 kHz clock is never altered.
// - Alarm hour bit 5 is PM flag in 12-hour, tens-of-20 in 24-hour.
// - In 12-hour mode midnight is 12 and noon is 32.
// - Each of seven mask bits selects one weekday value 000 to 110.
// - All mask bits zero means no weekly alarm ever.
// - Power-on flag clears the adjust register to zero.
// - Weekday counts 000 to 110 and wraps, stepping with the day.
// - Weekly alarm flag sets about 15 us after a match when enabled.
module rtc_calendar_adjust_weekly_alarm #(
	parameter int unsigned ALARM_DELAY = rtc_pkg::ALARM_DELAY_CYC
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave
	input  wire rtc_pkg::wb_req_s   wb_req_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	// Oscillator pin and its delivered copy
	input  wire logic               osc_i,
	output logic                    clk32k_o,
	// Neighbouring time logic
	input  wire rtc_pkg::time_now_s time_now_i,
	input  wire logic               day_carry_i,
	output logic                    second_tick_o,
	output rtc_pkg::calendar_s      calendar_o,
	// Control and flag logic
	input  wire logic               power_on_flag_i,
	input  wire logic               weekly_alarm_enable_i,
	input  wire logic               weekly_alarm_clear_i,
	output logic                    weekly_alarm_flag_o
);

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (ALARM_DELAY < 1 || ALARM_DELAY > 65535) begin : g_bad_delay
		$error("ALARM_DELAY must lie between 1 and 65535");
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function automatic logic is_leap(input logic [7:0] y);
		// Even tens need units 0, 4 or 8; odd tens need units 2 or 6.
		if (y[4] == 1'b0) begin
			is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		end else begin
			is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end
	endfunction

	function automatic logic [7:0] last_day(input logic [7:0] m, input logic leap);
		case (m)
			rtc_pkg::MONTH_FEB: last_day = leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
			rtc_pkg::MONTH_APR,
			rtc_pkg::MONTH_JUN,
			rtc_pkg::MONTH_SEP,
			rtc_pkg::MONTH_NOV: last_day = rtc_pkg::DAYS_30;
			default:            last_day = rtc_pkg::DAYS_31;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	// Ack comes one cycle after the request; writes land on the ack edge,
	// which is the edge at which the master samples ack high.
	logic        wb_req;
	logic [3:0]  wb_idx;
	logic        wb_mapped;
	logic        wr_fire;
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;

	rtc_pkg::calendar_s cal_q;
	rtc_pkg::calendar_s cal_d;
	logic [7:0]  adj_q;
	logic [7:0]  adj_d;
	logic [7:0]  amin_q;
	logic [7:0]  amin_d;
	logic [7:0]  ahour_q;
	logic [7:0]  ahour_d;
	logic [7:0]  amask_q;
	logic [7:0]  amask_d;
	logic        flag_q;

	assign wb_req    = wb_req_i.cyc & wb_req_i.stb;
	assign wb_idx    = wb_req_i.adr[5:2];
	assign wb_mapped = (wb_req_i.adr[7:6] == 2'b00) && (wb_req_i.adr[1:0] == 2'b00);
	assign wr_fire   = wb_req & ack_q & wb_req_i.we & wb_req_i.sel[0] & wb_mapped;

	always_comb begin
		ack_d  = wb_req & ~ack_q;
		rdat_d = 32'h0;
		if (wb_req && !ack_q && wb_mapped) begin
			case (wb_idx)
				rtc_pkg::IDX_WEEKDAY: rdat_d[2:0] = cal_q.weekday;
				rtc_pkg::IDX_DAY:     rdat_d[7:0] = cal_q.day;
				rtc_pkg::IDX_MONTH:   rdat_d[7:0] = cal_q.month;
				rtc_pkg::IDX_YEAR:    rdat_d[7:0] = cal_q.year;
				rtc_pkg::IDX_ADJUST:  rdat_d[7:0] = adj_q;
				rtc_pkg::IDX_AL_MIN:  rdat_d[7:0] = amin_q;
				rtc_pkg::IDX_AL_HOUR: rdat_d[7:0] = ahour_q;
				rtc_pkg::IDX_AL_MASK: rdat_d[7:0] = amask_q;
				default:              rdat_d      = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ------------------------------------------------------------------
	// Calendar and programmed registers
	// ------------------------------------------------------------------
	logic [7:0] month_end;
	logic       year_leap;

	assign year_leap = is_leap(cal_q.year);
	assign month_end = last_day(cal_q.month, year_leap);

	always_comb begin
		cal_d   = cal_q;
		adj_d   = adj_q;
		amin_d  = amin_q;
		ahour_d = ahour_q;
		amask_d = amask_q;
		if (day_carry_i) begin
			if (cal_q.weekday == rtc_pkg::WEEKDAY_LAST) begin
				cal_d.weekday = 3'h0;
			end else begin
				cal_d.weekday = cal_q.weekday + 3'h1;
			end
			if (cal_q.day == month_end) begin
				cal_d.day = rtc_pkg::DAY_FIRST;
				if (cal_q.month == rtc_pkg::MONTH_LAST) begin
					cal_d.month = rtc_pkg::MONTH_FIRST;
					if (cal_q.year == rtc_pkg::YEAR_LAST) begin
						cal_d.year = rtc_pkg::YEAR_FIRST;
					end else begin
						cal_d.year = bcd_inc(cal_q.year);
					end
				end else begin
					cal_d.month = bcd_inc(cal_q.month);
				end
			end else begin
				cal_d.day = bcd_inc(cal_q.day);
			end
		end
		// A host write in the carry cycle takes precedence over the carry.
		if (wr_fire) begin
			case (wb_idx)
				rtc_pkg::IDX_WEEKDAY: cal_d.weekday = wb_req_i.dat[2:0];
				rtc_pkg::IDX_DAY:     cal_d.day     = wb_req_i.dat[7:0] & rtc_pkg::MASK_DAY;
				rtc_pkg::IDX_MONTH:   cal_d.month   = wb_req_i.dat[7:0] & rtc_pkg::MASK_MONTH;
				rtc_pkg::IDX_YEAR:    cal_d.year    = wb_req_i.dat[7:0] & rtc_pkg::MASK_YEAR;
				rtc_pkg::IDX_ADJUST:  adj_d         = wb_req_i.dat[7:0] & rtc_pkg::MASK_ADJUST;
				rtc_pkg::IDX_AL_MIN:  amin_d        = wb_req_i.dat[7:0] & rtc_pkg::MASK_AL_MIN;
				rtc_pkg::IDX_AL_HOUR: ahour_d       = wb_req_i.dat[7:0] & rtc_pkg::MASK_AL_HOUR;
				rtc_pkg::IDX_AL_MASK: amask_d       = wb_req_i.dat[7:0] & rtc_pkg::MASK_AL_WDAY;
				default:              adj_d         = adj_q;
			endcase
		end
		if (power_on_flag_i) begin
			adj_d = 8'h00;
		end
	end

	// Calendar and alarm values have no documented power-up value; a plain
	// date is loaded so that simulation starts from a real calendar.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cal_q   <= '{day: rtc_pkg::DAY_FIRST, month: rtc_pkg::MONTH_FIRST,
			             year: rtc_pkg::YEAR_FIRST, weekday: 3'h0};
			adj_q   <= 8'h00;
			amin_q  <= 8'h00;
			ahour_q <= 8'h00;
			amask_q <= 8'h00;
		end else begin
			cal_q   <= cal_d;
			adj_q   <= adj_d;
			amin_q  <= amin_d;
			ahour_q <= ahour_d;
			amask_q <= amask_d;
		end
	end

	assign calendar_o = cal_q;

	// ------------------------------------------------------------------
	// Oscillator synchroniser and second divider
	// ------------------------------------------------------------------
	logic        osc_s1_q;
	logic        osc_s2_q;
	logic        osc_s3_q;
	logic        osc_lvl_q;
	logic        osc_lvl_d;
	logic        osc_rise;
	logic [16:0] cnt_q;
	logic [16:0] cnt_d;
	logic        apply_q;
	logic        apply_d;
	logic        tick_q;
	logic        tick_d;
	logic [5:0]  adj_mag;
	logic        corr_on;
	logic        sec_instant;
	logic [16:0] sec_len;

	assign adj_mag = adj_q[5:0];
	assign corr_on = apply_q && (adj_mag[5:1] != 5'h00);

	// Instants follow the seconds value of the second that is starting.
	assign sec_instant = (time_now_i.sec == rtc_pkg::SEC_00) ||
		(!adj_q[rtc_pkg::ADJ_INTERVAL_BIT] &&
		 ((time_now_i.sec == rtc_pkg::SEC_20) || (time_now_i.sec == rtc_pkg::SEC_40)));

	always_comb begin
		sec_len = rtc_pkg::NOMINAL_COUNT;
		if (corr_on) begin
			if (!adj_q[rtc_pkg::ADJ_DIR_BIT]) begin
				sec_len = rtc_pkg::NOMINAL_COUNT + {10'h000, adj_mag - 6'h01, 1'b0};
			end else begin
				sec_len = rtc_pkg::NOMINAL_COUNT - {10'h000, ~adj_mag + 6'h01, 1'b0};
			end
		end
	end

	always_comb begin
		osc_lvl_d = osc_lvl_q;
		if (osc_s2_q == osc_s3_q) begin
			osc_lvl_d = osc_s3_q;
		end
		cnt_d   = cnt_q;
		apply_d = apply_q;
		tick_d  = 1'b0;
		if (osc_rise) begin
			if (cnt_q == sec_len - 17'h00001) begin
				cnt_d   = 17'h00000;
				tick_d  = 1'b1;
				apply_d = 1'b0;
			end else begin
				cnt_d = cnt_q + 17'h00001;
			end
			if (cnt_q == 17'h00000) begin
				apply_d = sec_instant;
			end
		end
		if (wr_fire && wb_idx == rtc_pkg::IDX_ADJUST) begin
			apply_d = 1'b0;
		end
	end

	assign osc_rise = (osc_s2_q == osc_s3_q) && osc_s3_q && !osc_lvl_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_s1_q  <= 1'b0;
			osc_s2_q  <= 1'b0;
			osc_s3_q  <= 1'b0;
			osc_lvl_q <= 1'b0;
			cnt_q     <= 17'h00000;
			apply_q   <= 1'b0;
			tick_q    <= 1'b0;
		end else begin
			osc_s1_q  <= osc_i;
			osc_s2_q  <= osc_s1_q;
			osc_s3_q  <= osc_s2_q;
			osc_lvl_q <= osc_lvl_d;
			cnt_q     <= cnt_d;
			apply_q   <= apply_d;
			tick_q    <= tick_d;
		end
	end

	// The delivered clock is the filtered oscillator level, untouched by the divider.
	assign clk32k_o      = osc_lvl_q;
	assign second_tick_o = tick_q;

	// ------------------------------------------------------------------
	// Weekly alarm
	// ------------------------------------------------------------------
	// Hour compare is on the raw six bits, so bit 5 means PM or twenty and
	// 12 or 32 mean midnight or noon in both the alarm and the time counter.
	rtc_pkg::alarm_state_e st_q;
	rtc_pkg::alarm_state_e st_d;
	logic [15:0] dly_q;
	logic [15:0] dly_d;
	logic        flag_d;
	logic        al_match;
	logic        al_fire;

	assign al_match = (time_now_i.hour[5:0] == ahour_q[5:0]) &&
		(time_now_i.min == amin_q) &&
		amask_q[cal_q.weekday];

	always_comb begin
		st_d    = st_q;
		dly_d   = dly_q;
		al_fire = 1'b0;
		case (st_q)
			rtc_pkg::AL_IDLE: begin
				dly_d = 16'h0000;
				if (al_match && weekly_alarm_enable_i) begin
					st_d = rtc_pkg::AL_DELAY;
				end
			end
			rtc_pkg::AL_DELAY: begin
				dly_d = dly_q + 16'h0001;
				if (dly_q == 16'(ALARM_DELAY - 1)) begin
					al_fire = 1'b1;
					st_d    = rtc_pkg::AL_HELD;
				end
			end
			rtc_pkg::AL_HELD: begin
				if (!al_match) begin
					st_d = rtc_pkg::AL_IDLE;
				end
			end
			default: st_d = rtc_pkg::AL_IDLE;
		endcase
		if (!weekly_alarm_enable_i) begin
			st_d = rtc_pkg::AL_IDLE;
		end
		// A new alarm wins over a clear in the same cycle.
		flag_d = flag_q;
		if (weekly_alarm_clear_i) begin
			flag_d = 1'b0;
		end
		if (al_fire) begin
			flag_d = 1'b1;
		end
		if (!weekly_alarm_enable_i) begin
			flag_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q   <= rtc_pkg::AL_IDLE;
			dly_q  <= 16'h0000;
			flag_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			dly_q  <= dly_d;
			flag_q <= flag_d;
		end
	end

	assign weekly_alarm_flag_o = flag_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_day_to_month: assert property (@(posedge clk_i) disable iff (rst_i)
		(day_carry_i && !wr_fire && cal_q.day == month_end && cal_q.month == 8'h05)
		|=> (cal_q.day == 8'h01 && cal_q.month == 8'h06))
		else $error("day wrap did not advance the month");

	a_month_to_year: assert property (@(posedge clk_i) disable iff (rst_i)
		(day_carry_i && !wr_fire && cal_q.day == 8'h31 && cal_q.month == 8'h12)
		|=> (cal_q.month == 8'h01 && cal_q.year != $past(cal_q.year)))
		else $error("month wrap did not advance the year");

	a_feb_leap_day: assert property (@(posedge clk_i) disable iff (rst_i)
		(day_carry_i && !wr_fire && cal_q.month == 8'h02 && cal_q.day == 8'h28)
		|=> (cal_q.day == (is_leap($past(cal_q.year)) ? 8'h29 : 8'h01)))
		else $error("february length wrong");

	a_weekday_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		(day_carry_i && !wr_fire && cal_q.weekday == 3'h6) |=> (cal_q.weekday == 3'h0))
		else $error("weekday did not wrap after 110");

	a_adjust_por_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		power_on_flag_i |=> (adj_q == 8'h00))
		else $error("power-on flag did not clear adjust register");

	a_adjust_write_skip: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_fire && wb_idx == 4'h7) |=> !apply_q)
		else $error("correction survived an adjust write");

	a_small_mag_none: assert property (@(posedge clk_i) disable iff (rst_i)
		(adj_q[5:1] == 5'h00) |-> (sec_len == 17'h08000))
		else $error("correction applied with small magnitude");

	a_shorten_len: assert property (@(posedge clk_i) disable iff (rst_i)
		(apply_q && adj_q == 8'h7e) |-> (sec_len == 17'h07ffc))
		else $error("shortened second has wrong length");

	a_mask_zero_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(amask_q == 8'h00) |-> (!al_match && st_q != rtc_pkg::AL_DELAY))
		else $error("alarm matched with empty weekday mask");

	// Cycles since a match was taken, counted apart from the delay state so
	// that the delay is checked end to end; enable low clears the count to zero.
	logic [16:0] gap_q;
	logic [16:0] gap_d;

	always_comb begin
		gap_d = gap_q;
		if (!weekly_alarm_enable_i) begin
			gap_d = 17'h00000;
		end else if (st_q == rtc_pkg::AL_IDLE && al_match) begin
			gap_d = 17'h00001;
		end else if (gap_q != 17'h00000 && gap_q != 17'h1ffff) begin
			gap_d = gap_q + 17'h00001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_q <= 17'h00000;
		end else begin
			gap_q <= gap_d;
		end
	end

	a_flag_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(flag_q) |-> (gap_q == 17'(ALARM_DELAY + 1)))
		else $error("weekly alarm flag rose at the wrong time");

	a_flag_on_time: assert property (@(posedge clk_i) disable iff (rst_i)
		(gap_q == 17'(ALARM_DELAY + 1)) |-> flag_q)
		else $error("weekly alarm flag not set after the match delay");

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");

endmodule

/* File: verification/time_source.sv */
// Oscillator and seconds counter model standing beside the calendar block.
module time_source (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Block side
	input  wire logic          second_tick_i,
	input  wire logic [7:0]    min_i,
	input  wire logic [7:0]    hour_i,
	output logic               osc_o,
	output rtc_pkg::time_now_s time_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sec_q;
	// ------------------------------------------------------------------
	// Oscillator
	// ------------------------------------------------------------------
	// A fast oscillator keeps the run short; three cycles a half period still clears the filter.
	initial begin
		osc_o = 1'b0;
		forever begin
			repeat (3) @(posedge clk_i);
			osc_o <= ~osc_o;
		end
	end
	// ------------------------------------------------------------------
	// Seconds in BCD
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || (second_tick_i && sec_q == 8'h59)) begin
			sec_q <= 8'h00;
		end else if (second_tick_i) begin
			sec_q <= (sec_q[3:0] == 4'h9) ? {sec_q[7:4] + 4'h1, 4'h0} : sec_q + 8'h01;
		end
	end
	assign time_o = '{sec: sec_q, min: min_i, hour: hour_i};
endmodule

/* File: verification/rtc_calendar_adjust_weekly_alarm_test.sv */
// Self-checking bench for the calendar, adjust and weekly alarm block.
module rtc_calendar_adjust_weekly_alarm_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk_i = 1'b0;
	logic               rst_i;
	rtc_pkg::wb_req_s   wb_req;
	logic [31:0]        wb_dat;
	logic               wb_ack, osc, clk32k, day_carry, tick, power_on_flag, en, clr, flag;
	rtc_pkg::time_now_s time_now;
	rtc_pkg::calendar_s cal;
	logic [7:0]         min_v, hour_v, r;
	logic [31:0]        dates [10];
	int                 n_fail, n_compared, no, nc, n, yb, mb, ld;
	logic               po, pc;
	logic [63:0]        masks;
	logic [26:0]        last_exp;

	always #5 clk_i = ~clk_i;

	rtc_calendar_adjust_weekly_alarm #(.ALARM_DELAY(10)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .osc_i(osc),
		.clk32k_o(clk32k), .time_now_i(time_now), .day_carry_i(day_carry),
		.second_tick_o(tick), .calendar_o(cal), .power_on_flag_i(power_on_flag),
		.weekly_alarm_enable_i(en), .weekly_alarm_clear_i(clr), .weekly_alarm_flag_o(flag));
	time_source partner (.clk_i(clk_i), .rst_i(rst_i), .second_tick_i(tick), .min_i(min_v),
		.hour_i(hour_v), .osc_o(osc), .time_o(time_now));

	// ------------------------------------------------------------------
	// Checks and bus cycles
	// ------------------------------------------------------------------
	task chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_date(input logic [26:0] got, input logic [26:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The request is held until ack is seen at an edge; released requests leave one idle cycle.
	task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: {24'h0, d}};
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		r = wb_dat[7:0];
		wb_req <= '0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask

	// ------------------------------------------------------------------
	// Expected calendar
	// ------------------------------------------------------------------
	function logic [7:0] to_bcd(input int v);
		return {4'(v / 10), 4'(v % 10)};
	endfunction
	function logic [7:0] bcd_inc(input logic [7:0] v);
		return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction
	function logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
		if (m == 8'h02) return ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
		if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) return 8'h30;
		return 8'h31;
	endfunction
	function logic [26:0] next_date(input logic [7:0] d, m, y, input logic [2:0] w);
		logic [2:0] nw;
		nw = (w == 3'h6) ? 3'h0 : w + 3'h1;
		if (d != last_day(m, y)) return {bcd_inc(d), m, y, nw};
		if (m != 8'h12) return {8'h01, bcd_inc(m), y, nw};
		return {8'h01, 8'h01, (y == 8'h99) ? 8'h00 : bcd_inc(y), nw};
	endfunction
	task carry(input logic [31:0] e);
		wr(8'h10, e[31:24]);
		wr(8'h14, e[23:16]);
		wr(8'h18, e[15:8]);
		wr(8'h0c, e[7:0]);
		@(posedge clk_i);
		day_carry <= 1'b1;
		@(posedge clk_i);
		day_carry <= 1'b0;
		@(posedge clk_i);
		last_exp = next_date(e[31:24], e[23:16], e[15:8], e[2:0]);
		chk_date(cal, last_exp);
	endtask
	task alarm_try(input logic [7:0] w, input logic [7:0] m, input logic e);
		min_v <= 8'h31;
		clr <= 1'b1;
		wr(8'h0c, w);
		wr(8'h28, m);
		clr <= 1'b0;
		min_v <= 8'h30;
		repeat (20) @(posedge clk_i);
		chk_bit(flag, e);
	endtask

	task results();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		results();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'hd806a167));
		{rst_i, wb_req, day_carry, power_on_flag, en, clr} = {1'b1, 51'h0};
		{min_v, hour_v, n_fail, n_compared} = '0;
		dates = '{32'h28020106, 32'h28020400, 32'h29020401, 32'h28020002, 32'h30042303,
			32'h31012304, 32'h09051005, 32'h31129906, 32'h30111900, 32'h19124501};
		masks = {rtc_pkg::MASK_AL_WDAY, rtc_pkg::MASK_AL_HOUR, rtc_pkg::MASK_AL_MIN,
			rtc_pkg::MASK_ADJUST, rtc_pkg::MASK_YEAR, rtc_pkg::MASK_MONTH,
			rtc_pkg::MASK_DAY, rtc_pkg::MASK_WEEKDAY};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 8'h1c, 8'h00);
		chk_reg(r, 8'h00);
		foreach (dates[i]) begin
			wr(8'(12 + 4 * i), 8'hff);
			wb(1'b0, 8'(12 + 4 * i), 8'h00);
			chk_reg(r, i < 8 ? masks[8 * i +: 8] : 8'h00);
		end
		wr(8'h1c, 8'hc5);
		wb(1'b0, 8'h1c, 8'h00);
		chk_reg(r, 8'hc5);
		power_on_flag <= 1'b1;
		@(posedge clk_i);
		power_on_flag <= 1'b0;
		wb(1'b0, 8'h1c, 8'h00);
		chk_reg(r, 8'h00);
		// Only real dates are written, so every carry starts from a legal value.
		foreach (dates[i]) carry(dates[i]);
		repeat (20) begin
			yb = $urandom_range(99);
			mb = $urandom_range(12, 1);
			ld = $urandom_range(27, 1);
			if ($urandom_range(1)) ld = int'(last_day(to_bcd(mb), to_bcd(yb)));
			else ld = int'(to_bcd(ld));
			carry({8'(ld), to_bcd(mb), to_bcd(yb), 8'($urandom_range(6))});
		end
		wb(1'b0, 8'h18, 8'h00);
		chk_reg(r, last_exp[10:3]);
		{no, nc, po, pc} = {64'h0, osc, clk32k};
		repeat (300) begin
			@(posedge clk_i);
			no += int'(osc & ~po);
			nc += int'(clk32k & ~pc);
			{po, pc} = {osc, clk32k};
		end
		chk_bit(nc >= no - 1 && nc <= no + 1, 1'b1);
		wr(8'h0c, 8'h01);
		wr(8'h20, 8'h30);
		wr(8'h24, 8'h32);
		wr(8'h28, 8'h02);
		{min_v, hour_v} <= 16'h3032;
		repeat (3) @(posedge clk_i);
		chk_bit(flag, 1'b0);
		en <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (flag !== 1'b1 && n < 50);
		chk_bit(n inside {[11:14]}, 1'b1);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk_bit(flag, 1'b0);
		for (int w = 0; w < 7; w++) alarm_try(8'(w), 8'(1 << w), 1'b1);
		alarm_try(8'h06, 8'h00, 1'b0);
		alarm_try(8'h06, 8'h3f, 1'b0);
		en <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk_bit(flag, 1'b0);
		results();
	end
endmodule
